// *** hw/wpic_cfg.svh ***
// Offsets, field positions, reset values and codes of the register bank
`ifndef WPIC_CFG_SVH
`define WPIC_CFG_SVH

`define WPIC_ADDR_W 12
`define WPIC_IDX_INT_CFG 8'h7d
`define WPIC_IDX_KEY 8'h7e
`define WPIC_IDX_UPSEL 8'h7f
`define WPIC_IDX_MASK 8'h70
`define WPIC_IDX_STATUS 8'h71

`define WPIC_RST_INT_CFG 8'h02
`define WPIC_RST_KEY 8'h85
`define WPIC_RST_UPSEL 8'h00
`define WPIC_RST_MASK 8'h00
`define WPIC_RST_STATUS 8'h00

`define WPIC_KEY_OPEN 8'h85
`define WPIC_KEY_SINGLE 8'h86
`define WPIC_KEY_RELOCK 8'h00

`define WPIC_INT_CFG_BITS 8'h07
`define WPIC_BIT_POLARITY 0
`define WPIC_BIT_TRISTATE 1
`define WPIC_BIT_GPO 2

`define WPIC_EV_REFUSED 0
`define WPIC_EV_RELOCK 1

`define WPIC_SYNC_FILL 2'h3

`define WPIC_RESP_OKAY 2'h0
`define WPIC_RESP_DECERR 2'h3

`endif

// *** hw/wpic_pkg.sv ***
// Types shared by the register bank and its bench
`include "wpic_cfg.svh"
package wpic_pkg;

  typedef enum logic [1:0] {
    PROT_LOCKED,
    PROT_OPEN,
    PROT_SINGLE
  } wpic_prot_type;

  typedef enum logic {
    CAP_FILL,
    CAP_DONE
  } wpic_cap_type;

  typedef struct packed {
    logic awvalid;
    logic [`WPIC_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`WPIC_ADDR_W-1:0] araddr;
    logic rready;
  } wpic_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wpic_axi_rsp_type;

endpackage

// *** hw/wpic_top.sv ***
// AXI4-Lite bank for interrupt pin setup, write protection key and host select
`timescale 1ns/100ps
`default_nettype none
`include "wpic_cfg.svh"

module wpic_top #(
  parameter int UPSEL_W = 3
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire wpic_pkg::wpic_axi_req_type S_AXI_REQ,
  output var wpic_pkg::wpic_axi_rsp_type S_AXI_RSP,
  input wire logic [UPSEL_W-1:0] UPSEL_PINS,
  output var logic IRQ,
  output var logic IRQ_PIN_O,
  output var logic IRQ_PIN_OE
);
  import wpic_pkg::*;

  typedef struct packed {
    logic aw_have;
    logic aw_hit;
    logic [7:0] aw_idx;
    logic w_have;
    logic w_lane0;
    logic [7:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] int_cfg;
    logic [7:0] key;
    logic [7:0] upsel;
    logic [7:0] mask;
    logic [7:0] status;
    logic [UPSEL_W-1:0] sync1;
    logic [UPSEL_W-1:0] sync2;
    logic [UPSEL_W-1:0] sync3;
    wpic_cap_type cap;
    logic [1:0] fill;
  } wpic_state_type;

  wpic_state_type q;
  wpic_state_type d;
  wpic_prot_type mode;
  logic aw_rdy;
  logic w_rdy;
  logic ar_rdy;
  logic ev_refused;
  logic ev_relock;
  logic rd_clear;
  logic irq_active;
  logic [7:0] events;

  function automatic logic idx_known(input logic [7:0] idx);
    idx_known = (idx == `WPIC_IDX_INT_CFG) || (idx == `WPIC_IDX_KEY) ||
                (idx == `WPIC_IDX_UPSEL) || (idx == `WPIC_IDX_MASK) ||
                (idx == `WPIC_IDX_STATUS);
  endfunction

  function automatic logic addr_hit(input logic [`WPIC_ADDR_W-1:0] addr);
    addr_hit = (addr[`WPIC_ADDR_W-1:10] == '0) && idx_known(addr[9:2]);
  endfunction

  // Key decode: only two codes open the bank
  always_comb begin
    case (q.key)
      `WPIC_KEY_OPEN: mode = PROT_OPEN;
      `WPIC_KEY_SINGLE: mode = PROT_SINGLE;
      default: mode = PROT_LOCKED;
    endcase
  end

  // One write and one read in flight; a new address waits for the response
  assign aw_rdy = !q.aw_have && !q.bvalid;
  assign w_rdy = !q.w_have && !q.bvalid;
  assign ar_rdy = !q.rvalid;

  always_comb begin
    d = q;
    ev_refused = 1'b0;
    ev_relock = 1'b0;
    rd_clear = 1'b0;

    // Select pins: three stages, stable once the last two agree
    d.sync1 = UPSEL_PINS;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;

    case (q.cap)
      CAP_FILL: begin
        if (q.fill != `WPIC_SYNC_FILL) begin
          d.fill = q.fill + 2'h1;
        end else if (q.sync2 == q.sync3) begin
          d.upsel = 8'(q.sync3);
          d.cap = CAP_DONE;
        end
      end
      CAP_DONE: begin
        d.cap = CAP_DONE;
      end
      default: begin
        d.cap = CAP_DONE;
      end
    endcase

    // Write address and data are taken independently
    if (S_AXI_REQ.awvalid && aw_rdy) begin
      d.aw_have = 1'b1;
      d.aw_hit = addr_hit(S_AXI_REQ.awaddr);
      d.aw_idx = S_AXI_REQ.awaddr[9:2];
    end
    if (S_AXI_REQ.wvalid && w_rdy) begin
      d.w_have = 1'b1;
      d.w_lane0 = S_AXI_REQ.wstrb[0];
      d.w_data = S_AXI_REQ.wdata[7:0];
    end

    if (q.bvalid && S_AXI_REQ.bready) begin
      d.bvalid = 1'b0;
    end

    // A write without byte lane 0 changes nothing and spends no single unlock
    if (q.aw_have && q.w_have) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `WPIC_RESP_OKAY;
      if (!q.aw_hit) begin
        d.bresp = `WPIC_RESP_DECERR;
      end else if (!q.w_lane0) begin
        d.bresp = `WPIC_RESP_OKAY;
      end else if (q.aw_idx == `WPIC_IDX_KEY) begin
        d.key = q.w_data;
      end else if (q.aw_idx == `WPIC_IDX_STATUS) begin
        d.bresp = `WPIC_RESP_OKAY;
      end else if (mode == PROT_LOCKED) begin
        ev_refused = 1'b1;
      end else begin
        case (q.aw_idx)
          `WPIC_IDX_INT_CFG: begin
            d.int_cfg = q.w_data & `WPIC_INT_CFG_BITS;
          end
          `WPIC_IDX_UPSEL: begin
            d.upsel = q.w_data;
          end
          `WPIC_IDX_MASK: begin
            d.mask = q.w_data;
          end
          default: begin
            d.mask = q.mask;
          end
        endcase
        // Single unlock is spent by this write and the bank relocks
        if (mode == PROT_SINGLE) begin
          d.key = `WPIC_KEY_RELOCK;
          ev_relock = 1'b1;
        end
      end
    end

    // Reads answer one cycle after the address is taken
    if (q.rvalid && S_AXI_REQ.rready) begin
      d.rvalid = 1'b0;
    end
    if (S_AXI_REQ.arvalid && ar_rdy) begin
      d.rvalid = 1'b1;
      d.rresp = `WPIC_RESP_OKAY;
      d.rdata = 8'h00;
      if (!addr_hit(S_AXI_REQ.araddr)) begin
        d.rresp = `WPIC_RESP_DECERR;
      end else begin
        case (S_AXI_REQ.araddr[9:2])
          `WPIC_IDX_INT_CFG: begin
            d.rdata = q.int_cfg;
          end
          `WPIC_IDX_KEY: begin
            d.rdata = q.key;
          end
          `WPIC_IDX_UPSEL: begin
            d.rdata = q.upsel;
          end
          `WPIC_IDX_MASK: begin
            d.rdata = q.mask;
          end
          `WPIC_IDX_STATUS: begin
            d.rdata = q.status;
            rd_clear = 1'b1;
          end
          default: begin
            d.rdata = 8'h00;
          end
        endcase
      end
    end

    // Clearing read first, then new events, so an event is never lost
    events = 8'h00;
    events[`WPIC_EV_REFUSED] = ev_refused;
    events[`WPIC_EV_RELOCK] = ev_relock;
    if (rd_clear) begin
      d.status = 8'h00;
    end
    d.status = d.status | events;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      q <= '0;
      q.int_cfg <= `WPIC_RST_INT_CFG;
      q.key <= `WPIC_RST_KEY;
      q.upsel <= `WPIC_RST_UPSEL;
      q.mask <= `WPIC_RST_MASK;
      q.status <= `WPIC_RST_STATUS;
      q.cap <= CAP_FILL;
    end else begin
      q <= d;
    end
  end

  assign irq_active = |(q.status & q.mask);
  assign IRQ = irq_active;

  // General output mode holds the pin at the polarity bit level
  always_comb begin
    if (q.int_cfg[`WPIC_BIT_GPO]) begin
      IRQ_PIN_O = q.int_cfg[`WPIC_BIT_POLARITY];
    end else if (irq_active) begin
      IRQ_PIN_O = q.int_cfg[`WPIC_BIT_POLARITY];
    end else begin
      IRQ_PIN_O = !q.int_cfg[`WPIC_BIT_POLARITY];
    end
    // Floating when idle lets several sources share one wired line
    IRQ_PIN_OE = !q.int_cfg[`WPIC_BIT_TRISTATE] || irq_active ||
                 q.int_cfg[`WPIC_BIT_GPO];
  end

  always_comb begin
    S_AXI_RSP.awready = aw_rdy;
    S_AXI_RSP.wready = w_rdy;
    S_AXI_RSP.bvalid = q.bvalid;
    S_AXI_RSP.bresp = q.bresp;
    S_AXI_RSP.arready = ar_rdy;
    S_AXI_RSP.rvalid = q.rvalid;
    S_AXI_RSP.rdata = {24'h000000, q.rdata};
    S_AXI_RSP.rresp = q.rresp;
  end

endmodule
`default_nettype wire

// *** testbench/wpic_top_properties.sv ***
// Port checks for the register bank
`timescale 1ns/100ps
`default_nettype none
`include "wpic_cfg.svh"
module wpic_top_properties #(parameter int UPSEL_W = 3) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire wpic_pkg::wpic_axi_req_type S_AXI_REQ,
  input wire wpic_pkg::wpic_axi_rsp_type S_AXI_RSP,
  input wire logic [UPSEL_W-1:0] UPSEL_PINS,
  input wire logic IRQ,
  input wire logic IRQ_PIN_O,
  input wire logic IRQ_PIN_OE
);
  import wpic_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_active_driven: assert property (IRQ |-> IRQ_PIN_OE)
    else $error("pin not driven");
  a_reset_float: assert property ($rose(RESET_N) |-> !IRQ_PIN_OE && IRQ_PIN_O)
    else $error("pin after reset");
  a_pin_follows: assert property ($changed(IRQ) && $stable(S_AXI_RSP.bvalid)
    |-> $changed(IRQ_PIN_O)) else $error("pin level");
  a_read_answer: assert property (S_AXI_REQ.arvalid && S_AXI_RSP.arready
    |=> S_AXI_RSP.rvalid) else $error("no read answer");
  // Address and data are held one cycle before the response is registered
  a_write_answer: assert property (S_AXI_REQ.awvalid && S_AXI_RSP.awready &&
    S_AXI_REQ.wvalid && S_AXI_RSP.wready |-> ##2 S_AXI_RSP.bvalid)
    else $error("no write answer");
  a_write_busy: assert property (S_AXI_RSP.bvalid |-> !S_AXI_RSP.awready && !S_AXI_RSP.wready)
    else $error("write taken while busy");
  a_read_busy: assert property (S_AXI_RSP.rvalid |-> !S_AXI_RSP.arready)
    else $error("read taken while busy");
  a_unmapped_read: assert property (S_AXI_REQ.arvalid && S_AXI_RSP.arready &&
    S_AXI_REQ.araddr[11:10] != 2'h0 |=> S_AXI_RSP.rresp == `WPIC_RESP_DECERR)
    else $error("unmapped read");
  c_irq: cover property (IRQ);
  c_drive: cover property (!IRQ_PIN_OE ##1 IRQ_PIN_OE);
  c_decerr: cover property (S_AXI_RSP.rvalid && S_AXI_RSP.rresp == `WPIC_RESP_DECERR);
endmodule
bind wpic_top wpic_top_properties #(.UPSEL_W(UPSEL_W)) u_props (.CLK(CLK), .RESET_N(RESET_N),
  .S_AXI_REQ(S_AXI_REQ), .S_AXI_RSP(S_AXI_RSP), .UPSEL_PINS(UPSEL_PINS), .IRQ(IRQ),
  .IRQ_PIN_O(IRQ_PIN_O), .IRQ_PIN_OE(IRQ_PIN_OE));
`default_nettype wire

// *** testbench/wpic_host.sv ***
// Host processor model: AXI4-Lite master
`timescale 1ns/100ps
`default_nettype none
module wpic_host (
  input wire logic CLK,
  output var wpic_pkg::wpic_axi_req_type req,
  input wire wpic_pkg::wpic_axi_rsp_type rsp
);
  import wpic_pkg::*;
  // Response ready held high: simplest legal host
  initial begin
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= s;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    // Each channel is released at the edge that takes it, in either order
    while (!(aw_done && w_done)) begin
      @(posedge CLK);
      if (!aw_done && rsp.awready) begin
        aw_done = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_done && rsp.wready) begin
        w_done = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge CLK); while (!rsp.bvalid);
    r = rsp.bresp;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do @(posedge CLK); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge CLK); while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
  endtask
endmodule
`default_nettype wire

// *** testbench/test_write_protect_irq_config.sv ***
// Self-checking bench for the register bank
`timescale 1ns/100ps
`default_nettype none
`include "wpic_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %0t got %h want %h", $time, g, e); end end
module test_write_protect_irq_config;
  import wpic_pkg::*;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [2:0] UPSEL_PINS = 3'h5;
  wpic_axi_req_type req;
  wpic_axi_rsp_type rsp;
  logic IRQ;
  logic IRQ_PIN_O;
  logic IRQ_PIN_OE;
  int compares = 0;
  int miscompares = 0;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] keys [4] = '{8'h00, 8'h84, 8'h87, 8'hff};
  wpic_top u_dut (.CLK(CLK), .RESET_N(RESET_N), .S_AXI_REQ(req), .S_AXI_RSP(rsp),
    .UPSEL_PINS(UPSEL_PINS), .IRQ(IRQ), .IRQ_PIN_O(IRQ_PIN_O), .IRQ_PIN_OE(IRQ_PIN_OE));
  wpic_host u_host (.CLK(CLK), .req(req), .rsp(rsp));
  initial begin
    forever #10 CLK = ~CLK;
  end
  task automatic w(input logic [11:0] a, input logic [7:0] v);
    u_host.wr(a, {24'h0, v}, 4'hf, r);
    `CHK(r, `WPIC_RESP_OKAY)
  endtask
  task automatic c(input logic [11:0] a, input logic [7:0] e);
    u_host.rd(a, d, r);
    `CHK(d, {24'h0, e})
  endtask
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (8) @(posedge CLK);
    c(12'h1f4, 8'h02);
    c(12'h1f8, 8'h85);
    c(12'h1fc, 8'h05);
    `CHK(IRQ_PIN_OE, 1'b0)
    $display("test reset done");
    w(12'h1c0, 8'h03);
    w(12'h1f4, 8'h01);
    c(12'h1c0, 8'h03);
    `CHK({IRQ_PIN_OE, IRQ_PIN_O}, 2'b10)
    $display("test open done");
    foreach (keys[i]) begin
      w(12'h1f8, keys[i]);
      w(12'h1f4, 8'h03);
      c(12'h1f4, 8'h01);
      `CHK({IRQ_PIN_OE, IRQ_PIN_O}, 2'b11)
      c(12'h1c4, 8'h01);
    end
    $display("test locked done");
    w(12'h1f8, 8'h86);
    w(12'h1fc, 8'h02);
    w(12'h1f4, 8'h00);
    c(12'h1fc, 8'h02);
    c(12'h1f4, 8'h01);
    c(12'h1f8, 8'h00);
    c(12'h1c4, 8'h03);
    $display("test single done");
    w(12'h1f8, 8'h85);
    w(12'h1c0, 8'h00);
    w(12'h1f4, 8'h02);
    `CHK({IRQ_PIN_OE, IRQ_PIN_O}, 2'b01)
    u_host.rd(12'h400, d, r);
    `CHK(r, `WPIC_RESP_DECERR)
    $display("test float done");
    w(12'h1c0, 8'h01);
    w(12'h1f8, 8'h86);
    u_host.wr(12'h1c0, 32'h000000ff, 4'he, r);
    `CHK(r, `WPIC_RESP_OKAY)
    w(12'h1c4, 8'hff);
    c(12'h1f8, 8'h86);
    c(12'h1c0, 8'h01);
    c(12'h1c4, 8'h00);
    w(12'h1f4, 8'h02);
    w(12'h1f4, 8'h07);
    `CHK({IRQ, IRQ_PIN_OE, IRQ_PIN_O}, 3'b110)
    c(12'h1c4, 8'h03);
    `CHK({IRQ, IRQ_PIN_OE, IRQ_PIN_O}, 3'b001)
    $display("test strobe done");
    w(12'h1f8, 8'h85);
    w(12'h1f4, 8'h05);
    `CHK({IRQ, IRQ_PIN_OE, IRQ_PIN_O}, 3'b011)
    w(12'h1f4, 8'h04);
    `CHK({IRQ, IRQ_PIN_OE, IRQ_PIN_O}, 3'b010)
    $display("test general output done");
    // Second reset with other select pins: capture and defaults again
    UPSEL_PINS <= 3'h3;
    RESET_N <= 1'b0;
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (8) @(posedge CLK);
    c(12'h1fc, 8'h03);
    c(12'h1f4, 8'h02);
    c(12'h1f8, 8'h85);
    `CHK({IRQ, IRQ_PIN_OE, IRQ_PIN_O}, 3'b001)
    $display("test second reset done");
    print_verdict();
  end
  // Whole run needs a few microseconds
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
